//--- hdl/msurb_bank.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Upper register bank of a six-axis motion sensor, APB slave
module msurb_bank
    import msurb_pkg::*;
#(
    parameter logic [7:0]             IDENTITY = 8'h5A, // Arbitrary code
    parameter logic [FACTORY_N*8-1:0] FACTORY  = 48'h5D_61_66_52_57_5B
)
(
    input  wire logic                   i_mclk,          // 25 MHz core clock
    input  wire logic                   i_rst,           // Synchronous reset
    input  wire logic                   i_psel,          // APB select
    input  wire logic                   i_penable,       // APB enable
    input  wire logic                   i_pwrite,        // APB write
    input  wire logic [PADDR_W-1:0]     i_paddr,         // APB byte address
    input  wire logic [31:0]            i_pwdata,        // APB write data
    output logic                        o_pready,        // APB ready
    output logic      [31:0]            o_prdata,        // APB read data
    output logic                        o_pslverr,       // APB error
    input  wire logic                   i_sample_valid,  // New results strobe
    input  wire logic [15:0]            i_accel_y,       // Accel Y result
    input  wire logic [15:0]            i_accel_z,       // Accel Z result
    input  wire logic [15:0]            i_temperature,   // Temperature result
    input  wire logic [15:0]            i_rate_x,        // Rate X result
    input  wire logic [15:0]            i_rate_y,        // Rate Y result
    input  wire logic [15:0]            i_rate_z,        // Rate Z result
    input  wire logic [QUEUE_LVL_W-1:0] i_queue_level,   // Queue fill count
    input  wire logic [7:0]             i_queue_data,    // Queue head byte
    output logic                        o_queue_pop,     // Queue read pulse
    output logic                        o_queue_push,    // Queue write pulse
    output logic      [7:0]             o_queue_wdata,   // Queue write byte
    output logic                        o_sleep,         // Device asleep
    output logic      [7:0]             o_motion_ctrl,   // Motion logic control
    output logic      [7:0]             o_user_ctrl,     // User control
    output logic      [7:0]             o_power_two,     // Standby controls
    output logic      [AXES*TRIM_W-1:0] o_accel_trim     // Trims, X lowest
);
    // ======================================================================
    // State
    typedef struct packed {
        logic                   ready;
        logic                   slverr;
        logic [31:0]            rdata;
        logic [15:0]            accel_y;
        logic [15:0]            accel_z;
        logic [15:0]            temp;
        logic [15:0]            rate_x;
        logic [15:0]            rate_y;
        logic [15:0]            rate_z;
        logic [QUEUE_LVL_W-1:0] qlevel;
        logic [7:0]             motion;
        logic [7:0]             user;
        logic [7:0]             power_one;
        logic [7:0]             power_two;
        logic                   pop;
        logic                   push;
        logic [7:0]             qwdata;
    } msurb_state_type;

    msurb_state_type s_q;
    msurb_state_type s_d;

    logic [7:0]             idx;
    logic                   aligned;
    logic                   setup;
    logic                   access;
    logic                   wr_ok;
    logic                   soft_clear;
    logic [FACTORY_N*8-1:0] st_bytes;
    logic [7:0]             trim_high [AXES];
    logic [7:0]             trim_low  [AXES];
    logic [2:0]             st_slot;
    logic                   st_hit;

    // ======================================================================
    // Address decoding helpers
    function automatic logic is_factory(input logic [7:0] a);
        is_factory = (a <= IDX_GYRO_ST_X + 8'h02) ||
                     ((a >= IDX_ACCEL_ST_X) && (a <= IDX_ACCEL_ST_X + 8'h02));
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = is_factory(a) ||
                    ((a >= IDX_ACCEL_Y_L) && (a <= IDX_RATE_Z_L)) ||
                    ((a >= IDX_MOTION_CTRL) && (a <= IDX_POWER_TWO)) ||
                    ((a >= IDX_QUEUE_LVL_H) && (a <= IDX_IDENTITY)) ||
                    (a == IDX_TRIM_X_H) || (a == IDX_TRIM_X_L) ||
                    (a == IDX_TRIM_Y_H) || (a == IDX_TRIM_Y_L) ||
                    (a == IDX_TRIM_Z_H) || (a == IDX_TRIM_Z_L);
    endfunction

    // Power registers stay writable in sleep so software can wake the part
    function automatic logic may_write(input logic [7:0] a, input logic asleep);
        may_write = (a == IDX_POWER_ONE) || (a == IDX_POWER_TWO) || !asleep;
    endfunction

    // Bus phase decode
    assign idx     = i_paddr[PADDR_W-1:2];
    assign aligned = (i_paddr[1:0] == 2'b00);
    assign setup   = i_psel && !i_penable;
    assign access  = i_psel && i_penable && s_q.ready;
    assign wr_ok   = access && i_pwrite && !s_q.slverr &&
                     may_write(idx, s_q.power_one[POWER_SLEEP_BIT]);
    assign soft_clear = wr_ok && (idx == IDX_POWER_ONE) && i_pwdata[POWER_RESET_BIT];
    assign st_hit  = is_factory(idx);
    assign st_slot = (idx >= IDX_ACCEL_ST_X) ? 3'(idx - IDX_ACCEL_ST_X + 8'h03)
                                             : idx[2:0];

    // ======================================================================
    // Sub-blocks
    msurb_factory_store #(
        .FACTORY (FACTORY)
    ) u_factory (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_clear (soft_clear),
        .i_we    (wr_ok && st_hit),
        .i_slot  (st_slot),
        .i_wdata (i_pwdata[7:0]),
        .o_bytes (st_bytes)
    );

    // One trim pair per axis, high index steps by three
    for (genvar g = 0; g < AXES; g++) begin : g_trim
        localparam logic [7:0] HI = IDX_TRIM_X_H + 8'(3 * g);
        msurb_trim_axis u_trim (
            .i_mclk    (i_mclk),
            .i_rst     (i_rst),
            .i_clear   (soft_clear),
            .i_we_high (wr_ok && (idx == HI)),
            .i_we_low  (wr_ok && (idx == HI + 8'h01)),
            .i_wdata   (i_pwdata[7:0]),
            .o_high    (trim_high[g]),
            .o_low     (trim_low[g]),
            .o_trim    (o_accel_trim[g*TRIM_W +: TRIM_W])
        );
    end

    // ======================================================================
    // Next-state logic
    always_comb begin
        logic [7:0] rd;
        rd = 8'h00;
        s_d = s_q;
        // Read byte, chosen in the setup cycle so the answer is a register
        case (idx)
            IDX_ACCEL_Y_L:   rd = s_q.accel_y[7:0];
            IDX_ACCEL_Z_H:   rd = s_q.accel_z[15:8];
            IDX_ACCEL_Z_L:   rd = s_q.accel_z[7:0];
            IDX_TEMP_H:      rd = s_q.temp[15:8];
            IDX_TEMP_L:      rd = s_q.temp[7:0];
            IDX_RATE_X_H:    rd = s_q.rate_x[15:8];
            IDX_RATE_X_L:    rd = s_q.rate_x[7:0];
            IDX_RATE_Y_H:    rd = s_q.rate_y[15:8];
            IDX_RATE_Y_L:    rd = s_q.rate_y[7:0];
            IDX_RATE_Z_H:    rd = s_q.rate_z[15:8];
            IDX_RATE_Z_L:    rd = s_q.rate_z[7:0];
            IDX_MOTION_CTRL: rd = s_q.motion;
            IDX_USER_CTRL:   rd = s_q.user;
            IDX_POWER_ONE:   rd = s_q.power_one;
            IDX_POWER_TWO:   rd = s_q.power_two;
            IDX_QUEUE_LVL_H: rd = 8'({3'b000, s_q.qlevel[12:8]});
            IDX_QUEUE_LVL_L: rd = s_q.qlevel[7:0];
            IDX_QUEUE_DATA:  rd = i_queue_data;
            IDX_IDENTITY:    rd = IDENTITY;
            IDX_TRIM_X_H:    rd = trim_high[0];
            IDX_TRIM_X_L:    rd = trim_low[0];
            IDX_TRIM_Y_H:    rd = trim_high[1];
            IDX_TRIM_Y_L:    rd = trim_low[1];
            IDX_TRIM_Z_H:    rd = trim_high[2];
            IDX_TRIM_Z_L:    rd = trim_low[2];
            default: begin
                if (st_hit) begin
                    rd = st_bytes[st_slot*8 +: 8];
                end
            end
        endcase
        // Bus answer: ready in the first access cycle, no wait states
        s_d.ready  = setup;
        s_d.slverr = setup && !(aligned && is_mapped(idx));
        if (setup && !i_pwrite) begin
            s_d.rdata = (aligned && is_mapped(idx)) ? {24'h000000, rd} : 32'h00000000;
        end
        // Results are captured as whole words, so both halves stay paired
        if (i_sample_valid) begin
            s_d.accel_y = i_accel_y;
            s_d.accel_z = i_accel_z;
            s_d.temp    = i_temperature;
            s_d.rate_x  = i_rate_x;
            s_d.rate_y  = i_rate_y;
            s_d.rate_z  = i_rate_z;
        end
        s_d.qlevel = i_queue_level;
        // Queue port: pop after a read completes, push on a write while awake
        s_d.pop    = access && !i_pwrite && !s_q.slverr && (idx == IDX_QUEUE_DATA);
        s_d.push   = wr_ok && (idx == IDX_QUEUE_DATA);
        if (wr_ok && (idx == IDX_QUEUE_DATA)) begin
            s_d.qwdata = i_pwdata[7:0];
        end
        // Control writes; the identity index has no write path
        if (wr_ok) begin
            case (idx)
                IDX_MOTION_CTRL: s_d.motion    = i_pwdata[7:0];
                IDX_USER_CTRL:   s_d.user      = i_pwdata[7:0];
                IDX_POWER_ONE:   s_d.power_one = i_pwdata[7:0] & 8'h7F;
                IDX_POWER_TWO:   s_d.power_two = i_pwdata[7:0];
                default:         s_d.user      = s_d.user;
            endcase
        end
        // Soft device reset returns every register to its reset value
        if (soft_clear) begin
            s_d.accel_y   = 16'h0000;
            s_d.accel_z   = 16'h0000;
            s_d.temp      = 16'h0000;
            s_d.rate_x    = 16'h0000;
            s_d.rate_y    = 16'h0000;
            s_d.rate_z    = 16'h0000;
            s_d.motion    = RST_ZERO;
            s_d.user      = RST_ZERO;
            s_d.power_one = RST_POWER_ONE;
            s_d.power_two = RST_ZERO;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q           <= '0;
            s_q.power_one <= RST_POWER_ONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign o_pready      = s_q.ready;
    assign o_prdata      = s_q.rdata;
    assign o_pslverr     = s_q.slverr;
    assign o_queue_pop   = s_q.pop;
    assign o_queue_push  = s_q.push;
    assign o_queue_wdata = s_q.qwdata;
    assign o_sleep       = s_q.power_one[POWER_SLEEP_BIT];
    assign o_motion_ctrl = s_q.motion;
    assign o_user_ctrl   = s_q.user;
    assign o_power_two   = s_q.power_two;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_read_setup(logic [7:0] a);
        setup && !i_pwrite && aligned && (idx == a);
    endsequence

    sequence s_write_done(logic [7:0] a);
        access && i_pwrite && !s_q.slverr && (idx == a);
    endsequence

    property p_pair_high;
        logic [15:0] v;
        (s_read_setup(IDX_RATE_X_H), v = s_q.rate_x) |=>
            o_pready && (o_prdata == {24'h000000, v[15:8]});
    endproperty
    a_pair_high: assert property (p_pair_high) else $error("high byte mismatch");

    property p_pair_low;
        logic [15:0] v;
        (s_read_setup(IDX_TEMP_L), v = s_q.temp) |=> (o_prdata[7:0] == v[7:0]);
    endproperty
    a_pair_low: assert property (p_pair_low) else $error("low byte mismatch");

    property p_zero_reset;
        $past(i_rst) |-> (o_user_ctrl == 8'h00) && (o_motion_ctrl == 8'h00) &&
                         (o_power_two == 8'h00) && (o_accel_trim == '0);
    endproperty
    a_zero_reset: assert property (p_zero_reset) else $error("nonzero after reset");

    property p_power_reset;
        $past(i_rst) |-> (s_q.power_one == 8'h40) && o_sleep;
    endproperty
    a_power_reset: assert property (p_power_reset) else $error("power one reset");

    property p_factory_reset;
        $past(i_rst) |-> (st_bytes == FACTORY);
    endproperty
    a_factory_reset: assert property (p_factory_reset) else $error("factory lost");

    property p_identity;
        s_read_setup(IDX_IDENTITY) |=> o_pready && !o_pslverr &&
                                       (o_prdata == {24'h000000, IDENTITY});
    endproperty
    a_identity: assert property (p_identity) else $error("identity wrong");

    property p_sleep_block;
        (s_write_done(IDX_USER_CTRL) and o_sleep) |=> $stable(o_user_ctrl);
    endproperty
    a_sleep_block: assert property (p_sleep_block) else $error("write in sleep");

    property p_awake_write;
        logic [7:0] w;
        (s_write_done(IDX_USER_CTRL) and !o_sleep, w = i_pwdata[7:0]) |=>
            (o_user_ctrl == w);
    endproperty
    a_awake_write: assert property (p_awake_write) else $error("write lost");

    property p_wake;
        (s_write_done(IDX_POWER_ONE) and o_sleep and !i_pwdata[7] and !i_pwdata[6])
            |=> !o_sleep;
    endproperty
    a_wake: assert property (p_wake) else $error("cannot wake");

    // Queue writes reach the queue only while awake, with the written byte
    property p_awake_push;
        logic [7:0] w;
        (s_write_done(IDX_QUEUE_DATA) and !o_sleep, w = i_pwdata[7:0]) |=>
            o_queue_push && (o_queue_wdata == w);
    endproperty
    a_awake_push: assert property (p_awake_push) else $error("queue write lost");

    property p_sleep_push;
        (s_write_done(IDX_QUEUE_DATA) and o_sleep) |=> !o_queue_push;
    endproperty
    a_sleep_push: assert property (p_sleep_push) else $error("queue write in sleep");

    // Soft reset puts back the whole reset picture in one edge
    property p_soft_reset;
        (s_write_done(IDX_POWER_ONE) and i_pwdata[POWER_RESET_BIT]) |=>
            o_sleep && (o_user_ctrl == 8'h00) && (o_motion_ctrl == 8'h00) &&
            (o_power_two == 8'h00) && (o_accel_trim == '0) && (st_bytes == FACTORY);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
endmodule
`default_nettype wire

//--- hdl/msurb_pkg.sv
// ==========================================================================
// Register map and constants of the motion sensor upper register bank
package msurb_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_GYRO_ST_X   = 8'h00;
    localparam logic [7:0] IDX_ACCEL_ST_X  = 8'h0D;
    localparam logic [7:0] IDX_ACCEL_Y_L   = 8'h3E;
    localparam logic [7:0] IDX_ACCEL_Z_H   = 8'h3F;
    localparam logic [7:0] IDX_ACCEL_Z_L   = 8'h40;
    localparam logic [7:0] IDX_TEMP_H      = 8'h41;
    localparam logic [7:0] IDX_TEMP_L      = 8'h42;
    localparam logic [7:0] IDX_RATE_X_H    = 8'h43;
    localparam logic [7:0] IDX_RATE_X_L    = 8'h44;
    localparam logic [7:0] IDX_RATE_Y_H    = 8'h45;
    localparam logic [7:0] IDX_RATE_Y_L    = 8'h46;
    localparam logic [7:0] IDX_RATE_Z_H    = 8'h47;
    localparam logic [7:0] IDX_RATE_Z_L    = 8'h48;
    localparam logic [7:0] IDX_MOTION_CTRL = 8'h69;
    localparam logic [7:0] IDX_USER_CTRL   = 8'h6A;
    localparam logic [7:0] IDX_POWER_ONE   = 8'h6B;
    localparam logic [7:0] IDX_POWER_TWO   = 8'h6C;
    localparam logic [7:0] IDX_QUEUE_LVL_H = 8'h72;
    localparam logic [7:0] IDX_QUEUE_LVL_L = 8'h73;
    localparam logic [7:0] IDX_QUEUE_DATA  = 8'h74;
    localparam logic [7:0] IDX_IDENTITY    = 8'h75;
    localparam logic [7:0] IDX_TRIM_X_H    = 8'h77;
    localparam logic [7:0] IDX_TRIM_X_L    = 8'h78;
    localparam logic [7:0] IDX_TRIM_Y_H    = 8'h7A;
    localparam logic [7:0] IDX_TRIM_Y_L    = 8'h7B;
    localparam logic [7:0] IDX_TRIM_Z_H    = 8'h7D;
    localparam logic [7:0] IDX_TRIM_Z_L    = 8'h7E;
    // Reset values and fields
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_POWER_ONE   = 8'h40;
    localparam int         POWER_SLEEP_BIT = 6;
    localparam int         POWER_RESET_BIT = 7;
    localparam int         QUEUE_LVL_W     = 13;
    localparam int         TRIM_W          = 15;
    localparam int         AXES            = 3;
    localparam int         FACTORY_N       = 6;
    localparam int         PADDR_W         = 10;
endpackage

//--- hdl/msurb_trim_axis.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// One accelerometer trim, split over a high and a low byte register
module msurb_trim_axis
    import msurb_pkg::*;
(
    input  wire logic              i_mclk,     // Core clock
    input  wire logic              i_rst,      // Synchronous reset
    input  wire logic              i_clear,    // Soft device reset
    input  wire logic              i_we_high,  // Write high byte
    input  wire logic              i_we_low,   // Write low byte
    input  wire logic [7:0]        i_wdata,    // Write byte
    output logic      [7:0]        o_high,     // Trim bits 14..7
    output logic      [7:0]        o_low,      // Trim bits 6..0, bit 0 zero
    output logic      [TRIM_W-1:0] o_trim      // Whole trim value
);
    typedef struct packed {
        logic [TRIM_W-1:0] trim;
    } msurb_trim_type;

    msurb_trim_type s_q;
    msurb_trim_type s_d;

    // Low byte keeps its reserved bit 0 out of storage
    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d.trim = '0;
        end else begin
            if (i_we_high) begin
                s_d.trim[14:7] = i_wdata;
            end
            if (i_we_low) begin
                s_d.trim[6:0] = i_wdata[7:1];
            end
        end
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_high = s_q.trim[14:7];
    assign o_low  = {s_q.trim[6:0], 1'b0};
    assign o_trim = s_q.trim;
endmodule
`default_nettype wire

//--- hdl/msurb_factory_store.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Factory self-test bytes, loaded with their production values at reset
module msurb_factory_store
    import msurb_pkg::*;
#(
    parameter logic [FACTORY_N*8-1:0] FACTORY = 48'h5D_61_66_52_57_5B
)
(
    input  wire logic                   i_mclk,   // Core clock
    input  wire logic                   i_rst,    // Synchronous reset
    input  wire logic                   i_clear,  // Soft device reset
    input  wire logic                   i_we,     // Write one slot
    input  wire logic [2:0]             i_slot,   // Slot 0..5
    input  wire logic [7:0]             i_wdata,  // Write byte
    output logic      [FACTORY_N*8-1:0] o_bytes   // All slots, slot 0 lowest
);
    typedef struct packed {
        logic [FACTORY_N*8-1:0] mem;
    } msurb_store_type;

    msurb_store_type s_q;
    msurb_store_type s_d;

    // Reset restores production values, never zero
    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d.mem = FACTORY;
        end else if (i_we && (i_slot < 3'(FACTORY_N))) begin
            s_d.mem[i_slot*8 +: 8] = i_wdata;
        end
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q.mem <= FACTORY;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_bytes = s_q.mem;
endmodule
`default_nettype wire

//--- verif/msurb_testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the upper register bank, APB master and sensor side
module testbench
    import msurb_pkg::*;
;
    localparam logic [7:0]  IDENT = 8'h3C;                 // Arbitrary code
    localparam logic [47:0] FACT  = 48'h12_34_56_78_9A_BC; // Production bytes

    logic              i_mclk  = 1'b0;
    logic              i_rst   = 1'b1;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic              sv      = 1'b0;
    logic [9:0]        paddr   = 10'h000;
    logic [31:0]       pwdata  = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [15:0]       smp [0:5] = '{default: 16'h0};
    logic [12:0]       qlvl    = 13'h0;
    logic [7:0]        qdata   = 8'h00;
    logic              sleep;
    logic [7:0]        uc;
    logic [7:0]        p2;
    logic [7:0]        mc;
    logic [7:0]        qwd;
    logic              pop;
    logic              push;
    logic [44:0]       trim;
    logic [31:0]       seed    = 32'h62;
    int                miscompares = 0;
    int                checks_done = 0;
    logic [7:0]        zl [0:9] = '{IDX_ACCEL_Y_L, IDX_ACCEL_Z_H, IDX_TEMP_H, IDX_RATE_Z_L,
                                    IDX_MOTION_CTRL, IDX_USER_CTRL, IDX_POWER_TWO,
                                    IDX_TRIM_X_H, IDX_TRIM_Y_L, IDX_TRIM_Z_H};

    // ======================================================================
    // Clock, design and helpers
    always #20 i_mclk = ~i_mclk;

    msurb_bank #(.IDENTITY(IDENT), .FACTORY(FACT)) i_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_sample_valid(sv),
        .i_accel_y(smp[0]), .i_accel_z(smp[1]), .i_temperature(smp[2]),
        .i_rate_x(smp[3]), .i_rate_y(smp[4]), .i_rate_z(smp[5]),
        .i_queue_level(qlvl), .i_queue_data(qdata), .o_queue_pop(pop), .o_queue_push(push),
        .o_queue_wdata(qwd), .o_sleep(sleep), .o_motion_ctrl(mc), .o_user_ctrl(uc),
        .o_power_two(p2), .o_accel_trim(trim));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; ready, data and error are taken at the completing rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge i_mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge i_mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 8'h00, d, e);
        check(name, exp, d);
    endtask

    // Waits past the committing edge so outputs are settled when compared
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
        check("write error", 32'h0, {31'h0, e});
        @(negedge i_mclk);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        logic [7:0]  v;
        logic [15:0] old [0:5];
        logic [12:0] ql;
        logic [31:0] d;
        logic        e;
        int          k;
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        rdc("power one", IDX_POWER_ONE, 32'h40);
        rdc("identity", IDX_IDENTITY, {24'h0, IDENT});
        for (k = 0; k < 6; k++) rdc("self test", 8'(k < 3 ? k : k + 10), {24'h0, FACT[8*k +: 8]});
        foreach (zl[j]) rdc("reset zero", zl[j], 32'h0);
        check("sleep", 32'h1, {31'h0, sleep});
        // Asleep: only power registers take writes
        wr(IDX_USER_CTRL, 8'h5A);
        rdc("user asleep", IDX_USER_CTRL, 32'h0);
        wr(IDX_QUEUE_DATA, 8'h33);
        check("push asleep", 32'h0, {31'h0, push});
        v = 8'(rnd());
        wr(IDX_POWER_TWO, v);
        check("power two out", {24'h0, v}, {24'h0, p2});
        wr(IDX_POWER_ONE, 8'h00);
        check("awake", 32'h0, {31'h0, sleep});
        $display("test reset and sleep done");
        v = 8'(rnd());
        wr(IDX_USER_CTRL, v);
        check("user out", {24'h0, v}, {24'h0, uc});
        v = 8'(rnd());
        wr(IDX_MOTION_CTRL, v);
        check("motion out", {24'h0, v}, {24'h0, mc});
        wr(IDX_QUEUE_DATA, ~v);
        check("queue push", 32'h1, {31'h0, push});
        check("queue byte", {24'h0, ~v}, {24'h0, qwd});
        wr(IDX_IDENTITY, ~IDENT);
        rdc("identity kept", IDX_IDENTITY, {24'h0, IDENT});
        v = 8'(rnd());
        wr(IDX_TRIM_X_H, v);
        wr(IDX_TRIM_X_L, ~v);
        rdc("trim low", IDX_TRIM_X_L, {24'h0, ~v[7:1], 1'b0});
        check("trim x", {17'h0, v, ~v[7:1]}, {17'h0, trim[14:0]});
        apb(1'b0, 8'h76, 8'h00, d, e);
        check("unmapped err", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, d);
        $display("test access done");
        // Snapshot results, then move inputs without a strobe
        repeat (3) begin
            @(posedge i_mclk);
            for (k = 0; k < 6; k++) begin
                d = rnd();
                old[k] = d[15:0];
                smp[k] <= d[15:0];
            end
            sv <= 1'b1;
            @(posedge i_mclk);
            sv <= 1'b0;
            for (k = 0; k < 6; k++) begin
                d = rnd();
                smp[k] <= d[15:0];
            end
            ql = d[12:0];
            qlvl <= ql;
            qdata <= d[23:16];
            rdc("accel y low", IDX_ACCEL_Y_L, {24'h0, old[0][7:0]});
            for (k = 1; k < 6; k++) begin
                rdc("result high", 8'(8'h3D + 2*k), {24'h0, old[k][15:8]});
                rdc("result low", 8'(8'h3E + 2*k), {24'h0, old[k][7:0]});
            end
            rdc("level high", IDX_QUEUE_LVL_H, {27'h0, ql[12:8]});
            rdc("level low", IDX_QUEUE_LVL_L, {24'h0, ql[7:0]});
            rdc("queue data", IDX_QUEUE_DATA, {24'h0, d[23:16]});
            // Pop rises at the completing edge of the read and stays high for one cycle
            @(negedge i_mclk);
            check("queue pop", 32'h1, {31'h0, pop});
        end
        $display("test results done");
        // Soft reset brings back the reset picture
        wr(IDX_USER_CTRL, 8'hA5);
        wr(IDX_POWER_ONE, 8'h80);
        rdc("user cleared", IDX_USER_CTRL, 32'h0);
        rdc("trim cleared", IDX_TRIM_X_H, 32'h0);
        rdc("power one again", IDX_POWER_ONE, 32'h40);
        check("asleep again", 32'h1, {31'h0, sleep});
        $display("test soft reset done");
        summarize();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
